/* core/ssc_pkg.sv */
package ssc_pkg;

   // management link commands
   localparam logic [7:0] SSC_CMD_STATUS = 8'h55;
   localparam logic [7:0] SSC_CMD_SDR = 8'h60;
   // status value meaning all outputs on
   localparam logic [7:0] SSC_STATUS_ALL_ON = 8'h18;
   // byte that is sent once a response has run out
   localparam logic [7:0] SSC_FILL_BYTE = 8'hff;

   // status byte bit positions
   localparam int SSC_BIT_PIN_TURN_ON = 0;
   localparam int SSC_BIT_PIN_SUPPRESS = 1;
   localparam int SSC_BIT_SW_TURN_ON = 2;
   localparam int SSC_BIT_SW_SUPPRESS = 3;
   localparam int SSC_BIT_SW_SELECT = 4;
   localparam int SSC_BIT_OVERTEMP = 5;
   localparam int SSC_BIT_FAULT = 6;
   localparam int SSC_BIT_OVERRIDE = 7;

   // write frame lengths, command byte included
   localparam logic [2:0] SSC_WLEN_STATUS = 3'd3;
   localparam logic [2:0] SSC_WLEN_OVERRIDE = 3'd5;
   localparam logic [2:0] SSC_WLEN_SDR = 3'd2;
   localparam logic [2:0] SSC_WCOUNT_MAX = 3'd7;

   // read response byte indices
   localparam logic [2:0] SSC_RIDX_STATUS_CHK = 3'd2;
   localparam logic [2:0] SSC_RIDX_SDR_CHK = 3'd6;
   localparam logic [2:0] SSC_RIDX_MAX = 3'd7;

   // sensor data record store
   localparam int SSC_ROM_AW = 5;
   localparam logic [SSC_ROM_AW-1:0] SSC_SDR_COUNT = 5'd18;

   // default link address of the supply
   localparam logic [6:0] SSC_LINK_ADDR = 7'h23;

   // one sensor data record, all coefficients signed
   typedef struct packed {
      logic [7:0] number;
      logic signed [7:0] mult;
      logic signed [7:0] offset;
      logic signed [3:0] offset_exponent;
      logic signed [3:0] result_exponent;
   } ssc_sdr_t;

   // writable part of the status byte, bits 7 down to 2
   typedef struct packed {
      logic safety_override;
      logic fault_flag;
      logic overtemp_alert_flag;
      logic software_control_select;
      logic software_suppress_n;
      logic software_turn_on_n;
   } ssc_ctrl_t;

   localparam ssc_ctrl_t SSC_CTRL_RESET = 6'h00;

   typedef enum logic [3:0] {
      SSC_S_IDLE,
      SSC_S_ADDR,
      SSC_S_RX,
      SSC_S_ACKW,
      SSC_S_ACKH,
      SSC_S_TX,
      SSC_S_TXAW,
      SSC_S_TXACK,
      SSC_S_IGN
   } ssc_link_state_t;

   typedef struct packed {
      logic scl_meta;
      logic scl_sync;
      logic scl_prev;
      logic sda_meta;
      logic sda_sync;
      logic sda_prev;
      logic on_meta;
      logic on_sync;
      logic sup_meta;
      logic sup_sync;
      ssc_link_state_t st;
      logic [2:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic in_write;
      logic [7:0] cmd;
      logic [2:0] wcount;
      logic [7:0] d0;
      logic [7:0] d1;
      logic [7:0] d2;
      logic [7:0] wsum;
      logic [SSC_ROM_AW-1:0] sdr_idx;
      logic [2:0] rd_idx;
      logic [7:0] tx;
      logic [7:0] rsum;
      ssc_ctrl_t ctrl;
      logic nonrec_prev;
      logic sda_oe_n;
      logic sda_out;
      logic outputs_on;
      logic event_msg;
      logic override_active;
   } ssc_state_t;

endpackage

/* core/ssc_sdr_rom.sv */
`timescale 1ns/1ns
module ssc_sdr_rom (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // record lookup
   input wire logic [ssc_pkg::SSC_ROM_AW-1:0] addr,
   output ssc_pkg::ssc_sdr_t rdata
);
   import ssc_pkg::*;

   ssc_sdr_t rdata_reg;
   ssc_sdr_t rdata_next;

   // record table: number, multiplier, offset, offset exponent, result exponent
   always_comb begin
      case (addr)
         5'd0: rdata_next = {8'h07, 8'h14, 8'h5a, 4'h1, 4'he};
         5'd1: rdata_next = {8'h08, 8'h14, 8'h5a, 4'h2, 4'hd};
         5'd2: rdata_next = {8'h0a, 8'h0a, 8'h23, 4'h2, 4'hd};
         5'd3: rdata_next = {8'h0b, 8'h0a, 8'h14, 4'h2, 4'hd};
         5'd4: rdata_next = {8'h0c, 8'h14, 8'h5a, 4'h2, 4'hd};
         5'd5: rdata_next = {8'h0d, 8'hec, 8'ha6, 4'h2, 4'hd}; // negative rail, signed
         5'd6: rdata_next = {8'h0e, 8'h04, 8'h00, 4'h0, 4'hf};
         5'd7: rdata_next = {8'h0f, 8'h04, 8'h00, 4'h0, 4'hf};
         5'd8: rdata_next = {8'h11, 8'h14, 8'h00, 4'h0, 4'he};
         5'd9: rdata_next = {8'h12, 8'h01, 8'h14, 4'h1, 4'h0};
         5'd10: rdata_next = {8'h13, 8'h01, 8'h14, 4'h1, 4'h0};
         5'd11: rdata_next = {8'h15, 8'h32, 8'h00, 4'h0, 4'hf};
         5'd12: rdata_next = {8'h16, 8'h28, 8'h00, 4'h0, 4'hf};
         5'd13: rdata_next = {8'h18, 8'h0a, 8'h00, 4'h0, 4'hf};
         5'd14: rdata_next = {8'h19, 8'h14, 8'h00, 4'h0, 4'he};
         5'd15: rdata_next = {8'h1a, 8'h14, 8'h00, 4'h0, 4'hd};
         5'd16: rdata_next = {8'h1b, 8'h14, 8'h00, 4'h0, 4'hd};
         5'd17: rdata_next = {8'h1c, 8'h0a, 8'h00, 4'h0, 4'hf};
         default: rdata_next = '0; // beyond the table reads as an empty record
      endcase
   end

   // registered read data
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;

endmodule

/* core/ssc_status_ctrl.sv */
`timescale 1ns/1ns
module ssc_status_ctrl #(
   parameter logic [6:0] LINK_ADDR = ssc_pkg::SSC_LINK_ADDR
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // management link pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // backplane pins, active low
   input wire logic pin_turn_on_n,
   input wire logic pin_suppress_n,
   // supply monitor events
   input wire logic fault_event,
   input wire logic overtemp_fault,
   input wire logic nonrec_active,
   // supply control and status
   output logic outputs_on,
   output logic event_msg,
   output logic override_active,
   output logic [7:0] status_byte
);
   import ssc_pkg::*;

   ssc_state_t s;
   ssc_state_t n;
   ssc_sdr_t rec;
   logic [7:0] status_now;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic [7:0] rx_byte;
   logic turn_on_act;
   logic suppress_act;
   logic shutdown;

   // response byte for the current command at a given index
   function automatic logic [7:0] resp_byte(input logic [7:0] cmd, input logic [2:0] idx,
                                            input logic [7:0] status, input ssc_sdr_t r,
                                            input logic [7:0] sum);
      logic [7:0] b;
      b = SSC_FILL_BYTE;
      if (idx == 3'd0) begin
         b = cmd;
      end else if (cmd == SSC_CMD_STATUS) begin
         if (idx == 3'd1) begin
            b = status;
         end else if (idx == SSC_RIDX_STATUS_CHK) begin
            b = 8'h00 - sum; // zero-sum checksum
         end
      end else if (cmd == SSC_CMD_SDR) begin
         case (idx)
            3'd1: b = r.number; // record fields in query order
            3'd2: b = r.mult;
            3'd3: b = r.offset;
            3'd4: b = {{4{r.offset_exponent[3]}}, r.offset_exponent}; // sign kept
            3'd5: b = {{4{r.result_exponent[3]}}, r.result_exponent};
            SSC_RIDX_SDR_CHK: b = 8'h00 - sum;
            default: b = SSC_FILL_BYTE;
         endcase
      end else if (idx == 3'd1) begin
         b = 8'h00 - sum;
      end
      return b;
   endfunction

   ssc_sdr_rom u_rom (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .addr(s.sdr_idx),
      .rdata(rec)
   );

   // link events from the synchronised pins
   assign scl_rise = s.scl_sync & ~s.scl_prev;
   assign scl_fall = ~s.scl_sync & s.scl_prev;
   assign bus_start = s.scl_sync & s.scl_prev & s.sda_prev & ~s.sda_sync;
   assign bus_stop = s.scl_sync & s.scl_prev & ~s.sda_prev & s.sda_sync;
   assign rx_byte = {s.shreg[6:0], s.sda_sync};

   // live status: control bits plus the pin levels
   assign status_now = {s.ctrl, s.sup_sync, s.on_sync}; // pins read back live

   // who steers the outputs, software or pins
   assign turn_on_act = s.ctrl.software_control_select ? ~s.ctrl.software_turn_on_n
                                                       : ~s.on_sync;
   assign suppress_act = s.ctrl.software_control_select ? ~s.ctrl.software_suppress_n
                                                        : ~s.sup_sync;
   assign shutdown = nonrec_active & ~s.ctrl.safety_override; // override holds off

   // next state
   always_comb begin
      n = s;
      // two-stage synchronisers, then a history stage for edge finding
      n.scl_meta = scl_in;
      n.scl_sync = s.scl_meta;
      n.scl_prev = s.scl_sync;
      n.sda_meta = sda_in;
      n.sda_sync = s.sda_meta;
      n.sda_prev = s.sda_sync;
      n.on_meta = pin_turn_on_n;
      n.on_sync = s.on_meta;
      n.sup_meta = pin_suppress_n;
      n.sup_sync = s.sup_meta;
      n.sda_out = 1'b0;

      if (bus_start || bus_stop) begin
         // close a write frame and act on it
         if (s.in_write && s.cmd == SSC_CMD_STATUS && s.wsum == 8'h00) begin
            if (s.wcount == SSC_WLEN_STATUS) begin
               n.ctrl = s.d0[7:2];
               // a single copy may clear override but never set it
               n.ctrl.safety_override = s.d0[SSC_BIT_OVERRIDE] & s.ctrl.safety_override;
            end else if (s.wcount == SSC_WLEN_OVERRIDE && s.d0 == s.d1 && s.d1 == s.d2) begin
               n.ctrl = s.d0[7:2]; // three matching copies may set override
            end
         end
         if (s.in_write && s.cmd == SSC_CMD_SDR && s.wcount == SSC_WLEN_SDR) begin
            n.sdr_idx = s.d0[SSC_ROM_AW-1:0]; // selects the record to report
         end
         n.in_write = 1'b0;
         n.wcount = 3'd0;
         n.wsum = 8'h00;
         n.bitcnt = 3'd0;
         n.sda_oe_n = 1'b1;
         n.st = bus_start ? SSC_S_ADDR : SSC_S_IDLE;
      end else begin
         case (s.st)
            SSC_S_IDLE: begin
               n.st = SSC_S_IDLE;
            end
            SSC_S_ADDR: begin
               if (scl_rise) begin
                  n.shreg = rx_byte;
                  n.bitcnt = s.bitcnt + 3'd1;
                  if (s.bitcnt == 3'd7) begin
                     if (rx_byte[7:1] == LINK_ADDR) begin
                        n.st = SSC_S_ACKW;
                        n.rw = rx_byte[0];
                        n.in_write = ~rx_byte[0];
                        n.rd_idx = 3'd0;
                        n.rsum = 8'h00;
                        n.tx = resp_byte(s.cmd, 3'd0, status_now, rec, 8'h00);
                     end else begin
                        n.st = SSC_S_IGN;
                     end
                  end
               end
            end
            SSC_S_RX: begin
               if (scl_rise) begin
                  n.shreg = rx_byte;
                  n.bitcnt = s.bitcnt + 3'd1;
                  if (s.bitcnt == 3'd7) begin
                     // byte store by position in the frame
                     case (s.wcount)
                        3'd0: n.cmd = rx_byte;
                        3'd1: n.d0 = rx_byte;
                        3'd2: n.d1 = rx_byte;
                        3'd3: n.d2 = rx_byte;
                        default: n.d2 = s.d2;
                     endcase
                     n.wsum = s.wsum + rx_byte;
                     if (s.wcount != SSC_WCOUNT_MAX) begin
                        n.wcount = s.wcount + 3'd1;
                     end
                     n.st = SSC_S_ACKW;
                  end
               end
            end
            SSC_S_ACKW: begin
               if (scl_fall) begin
                  n.sda_oe_n = 1'b0; // pull low to acknowledge
                  n.st = SSC_S_ACKH;
               end
            end
            SSC_S_ACKH: begin
               if (scl_fall) begin
                  n.bitcnt = 3'd0;
                  if (s.rw) begin
                     n.sda_oe_n = s.tx[7];
                     n.st = SSC_S_TX;
                  end else begin
                     n.sda_oe_n = 1'b1;
                     n.st = SSC_S_RX;
                  end
               end
            end
            SSC_S_TX: begin
               if (scl_fall) begin
                  n.sda_oe_n = s.tx[3'd7 - s.bitcnt]; // open drain, msb first
               end
               if (scl_rise) begin
                  n.bitcnt = s.bitcnt + 3'd1;
                  if (s.bitcnt == 3'd7) begin
                     n.st = SSC_S_TXAW;
                  end
               end
            end
            SSC_S_TXAW: begin
               if (scl_fall) begin
                  n.sda_oe_n = 1'b1; // release for the manager's acknowledge
                  n.rsum = s.rsum + s.tx;
                  if (s.rd_idx != SSC_RIDX_MAX) begin
                     n.rd_idx = s.rd_idx + 3'd1;
                  end
                  n.st = SSC_S_TXACK;
               end
            end
            SSC_S_TXACK: begin
               if (scl_rise) begin
                  if (!s.sda_sync) begin
                     n.tx = resp_byte(s.cmd, s.rd_idx, status_now, rec, s.rsum);
                     n.bitcnt = 3'd0;
                     n.st = SSC_S_TX;
                  end else begin
                     n.st = SSC_S_IGN;
                  end
               end
            end
            SSC_S_IGN: begin
               n.st = SSC_S_IGN;
            end
            default: begin
               n.st = SSC_S_IDLE;
            end
         endcase
      end

      // hardware clears win over a manager write in the same cycle
      if (fault_event) begin
         n.ctrl.fault_flag = 1'b0;
      end
      if (overtemp_fault) begin
         n.ctrl.overtemp_alert_flag = 1'b0;
      end

      // event messages keep flowing under override
      n.nonrec_prev = nonrec_active;
      n.event_msg = fault_event | overtemp_fault | (nonrec_active & ~s.nonrec_prev);
      n.outputs_on = turn_on_act & ~suppress_act & ~shutdown;
      n.override_active = s.ctrl.safety_override;
   end

   // state register, synchronous reset
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s <= '0;
         s.ctrl <= SSC_CTRL_RESET; // bits 7 to 2 cleared
         s.scl_meta <= 1'b1;
         s.scl_sync <= 1'b1;
         s.scl_prev <= 1'b1;
         s.sda_meta <= 1'b1;
         s.sda_sync <= 1'b1;
         s.sda_prev <= 1'b1;
         s.on_meta <= 1'b1;
         s.on_sync <= 1'b1;
         s.sup_meta <= 1'b1;
         s.sup_sync <= 1'b1;
         s.sda_oe_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // outputs straight from the state register
   assign sda_out = s.sda_out;
   assign sda_oe_n = s.sda_oe_n;
   assign outputs_on = s.outputs_on;
   assign event_msg = s.event_msg;
   assign override_active = s.override_active;
   assign status_byte = {s.ctrl, s.sup_sync, s.on_sync};

endmodule

/* verification/ssc_status_ctrl_monitor.sv */
`timescale 1ns/1ns
module ssc_status_ctrl_monitor #(
   parameter logic [6:0] LINK_ADDR = 7'h23
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // link pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // backplane pins and monitor events
   input wire logic pin_turn_on_n,
   input wire logic pin_suppress_n,
   input wire logic fault_event,
   input wire logic overtemp_fault,
   input wire logic nonrec_active,
   // control and status
   input wire logic outputs_on,
   input wire logic event_msg,
   input wire logic override_active,
   input wire logic [7:0] status_byte
);
   // every check runs on the system clock and sleeps in reset
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   reset_clear_a: assert property (
      $rose(resetn) |-> status_byte[7:2] == 6'h00 && !outputs_on)
      else $error("control bits not clear after reset");
   fault_clear_a: assert property (
      fault_event |-> ##[1:2] !status_byte[6])
      else $error("fault flag survived a fault");
   overtemp_clear_a: assert property (
      overtemp_fault |-> ##[1:2] !status_byte[5])
      else $error("overtemperature flag survived a fault");
   event_report_a: assert property (
      fault_event || overtemp_fault || $rose(nonrec_active) |-> ##[1:2] event_msg)
      else $error("event message missing");
   nonrec_off_a: assert property (
      (nonrec_active && !status_byte[7])[*2] |=> !outputs_on)
      else $error("outputs left on in a non-recoverable state");
   override_keep_a: assert property (
      $rose(nonrec_active) && status_byte[7] && outputs_on |=> outputs_on)
      else $error("outputs shut down under override");
   pins_live_a: assert property (
      ($stable(pin_turn_on_n) && $stable(pin_suppress_n))[*4]
      |-> status_byte[1:0] == {pin_suppress_n, pin_turn_on_n})
      else $error("pin status bits do not follow pins");
   sw_control_a: assert property (
      (status_byte[4] && !nonrec_active && $stable(status_byte[3:2]))[*3]
      |-> outputs_on == (status_byte[3] && !status_byte[2]))
      else $error("software control bits not obeyed");
   hw_control_a: assert property (
      (!status_byte[4] && !nonrec_active && $stable(status_byte[1:0]))[*3]
      |-> outputs_on == (!status_byte[0] && status_byte[1]))
      else $error("pins not in control");
endmodule

bind ssc_status_ctrl ssc_status_ctrl_monitor #(
   .LINK_ADDR(LINK_ADDR)
) u_ssc_status_ctrl_monitor (
   .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pin_turn_on_n(pin_turn_on_n),
   .pin_suppress_n(pin_suppress_n), .fault_event(fault_event),
   .overtemp_fault(overtemp_fault), .nonrec_active(nonrec_active),
   .outputs_on(outputs_on), .event_msg(event_msg),
   .override_active(override_active), .status_byte(status_byte)
);

/* verification/ssc_mgr.sv */
`timescale 1ns/1ns
module ssc_mgr (
   // pacing clock
   input wire logic clk_sys,
   // link wires, data pulled up when released
   output logic scl,
   output logic sda_low,
   input wire logic sda_wire
);
   logic [7:0] rx_q[$];
   int nacks;
   // link stands idle with both lines high
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // quarter of the 160 ns link period
   task automatic q4();
      repeat (4) @(negedge clk_sys);
   endtask
   // data changes only while the link clock is low
   task automatic put_bit(input logic b);
      sda_low = !b;
      q4();
      scl = 1'b1;
      q4();
      q4();
      scl = 1'b0;
      q4();
   endtask
   // released line, sampled mid-way through the high phase
   task automatic get_bit(output logic b);
      sda_low = 1'b0;
      q4();
      scl = 1'b1;
      q4();
      b = sda_wire;
      q4();
      scl = 1'b0;
      q4();
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic start();
      sda_low = 1'b0;
      q4();
      scl = 1'b1;
      q4();
      sda_low = 1'b1;
      q4();
      scl = 1'b0;
      q4();
   endtask
   // stop: data rises while the clock is high, then the link rests
   task automatic stop();
      sda_low = 1'b1;
      q4();
      scl = 1'b1;
      q4();
      sda_low = 1'b0;
      q4();
   endtask
   // byte out, top bit first, then the acknowledge
   task automatic send(input logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(a);
      if (a !== 1'b0) begin
         nacks++;
      end
   endtask
   // byte in; the last one of a read is refused
   task automatic recv(input logic last);
      logic [7:0] d;
      logic b;
      for (int i = 7; i >= 0; i--) begin
         get_bit(b);
         d[i] = b;
      end
      rx_q.push_back(d);
      put_bit(last);
   endtask
   // write phase, then an optional read after a repeated start
   task automatic xfer(input logic [6:0] addr, input logic [7:0] wq[$], input int nrd);
      nacks = 0;
      rx_q.delete();
      start();
      send({addr, 1'b0});
      foreach (wq[i]) begin
         send(wq[i]);
      end
      if (nrd > 0) begin
         start();
         send({addr, 1'b1});
         for (int i = 0; i < nrd; i++) begin
            recv(i == nrd - 1);
         end
      end
      stop();
   endtask
   // raw reading to engineering value from signed record constants
   function automatic real to_eng(input int x, input int m, input int b, input int k1,
                                  input int k2);
      return (m * x + b * 10.0 ** k1) * 10.0 ** k2;
   endfunction
endmodule

/* verification/test_ssc_status_ctrl.sv */
`timescale 1ns/1ns
module test_ssc_status_ctrl;
   import ssc_pkg::*;
   logic clk_sys, resetn, scl, sda_low, sda_out, sda_oe_n, pin_turn_on_n, pin_suppress_n;
   logic fault_event, overtemp_fault, nonrec_active, outputs_on, event_msg, override_active;
   logic [7:0] status_byte;
   wire logic sda_wire;
   int bad_count = 0;
   int num_checks = 0;

   // pulled-up data line, low while either party pulls it
   assign sda_wire = !sda_low && (sda_oe_n || sda_out);

   // design and manager
   ssc_status_ctrl u_ssc_status_ctrl (
      .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pin_turn_on_n(pin_turn_on_n),
      .pin_suppress_n(pin_suppress_n), .fault_event(fault_event),
      .overtemp_fault(overtemp_fault), .nonrec_active(nonrec_active),
      .outputs_on(outputs_on), .event_msg(event_msg), .override_active(override_active),
      .status_byte(status_byte)
   );
   ssc_mgr u_ssc_mgr (.clk_sys(clk_sys), .scl(scl), .sda_low(sda_low), .sda_wire(sda_wire));

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // byte comparison with mismatch report
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic settle();
      repeat (8) @(negedge clk_sys);
   endtask
   task automatic do_reset();
      resetn = 1'b0;
      repeat (12) @(negedge clk_sys);
      resetn = 1'b1;
      settle();
   endtask
   // watches for the event strobe while ending any one-cycle pulse
   task automatic see_ev(input string what);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_sys);
         fault_event = 1'b0;
         overtemp_fault = 1'b0;
         if (event_msg === 1'b1) seen = 1'b1;
      end
      check(what, 8'h01, {7'h00, seen});
   endtask
   // status write frame with a zero-sum trailer
   task automatic wrq(input logic [7:0] q[$]);
      logic [7:0] s;
      s = 8'h00;
      foreach (q[i]) s -= q[i];
      q.push_back(s);
      u_ssc_mgr.xfer(SSC_LINK_ADDR, q, 0);
      check("write acks", 8'h00, 8'(u_ssc_mgr.nacks));
      settle();
   endtask
   task automatic wr(input logic [7:0] d, input int copies);
      logic [7:0] q[$];
      q = {SSC_CMD_STATUS};
      repeat (copies) q.push_back(d);
      wrq(q);
   endtask
   task automatic rd_status(input logic [7:0] exp);
      u_ssc_mgr.xfer(SSC_LINK_ADDR, {SSC_CMD_STATUS}, 3);
      check("status echo", SSC_CMD_STATUS, u_ssc_mgr.rx_q[0]);
      check("status read", exp, u_ssc_mgr.rx_q[1]);
      check("status sum", 8'h00 - SSC_CMD_STATUS - exp, u_ssc_mgr.rx_q[2]);
   endtask

   // reset values and live pin levels
   task automatic t_pins();
      check("reset status", 8'h02, status_byte);
      check("pins on", 8'h01, {7'h00, outputs_on});
      pin_suppress_n = 1'b0;
      settle();
      check("pin bits", 8'h00, status_byte);
      check("pin suppress", 8'h00, {7'h00, outputs_on});
      pin_suppress_n = 1'b1;
      settle();
   endtask
   // software control table, pins holding turn-on off
   task automatic t_soft();
      logic [7:0] wv[4] = '{8'h18, 8'h10, 8'h1c, 8'h0b};
      logic [7:0] on[4] = '{8'h01, 8'h00, 8'h00, 8'h00};
      pin_turn_on_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(wv[i], 1);
         check("soft on", on[i], {7'h00, outputs_on});
         rd_status({wv[i][7:2], 2'b11});
      end
      pin_turn_on_n = 1'b0;
      settle();
      check("pins back", 8'h01, {7'h00, outputs_on});
   endtask
   // override needs three equal copies and keeps the supply running
   task automatic t_override();
      wr(8'h88, 1);
      check("single copy", 8'h00, {7'h00, override_active});
      wrq({SSC_CMD_STATUS, 8'h88, 8'h88, 8'h89});
      check("unequal copies", 8'h00, {7'h00, override_active});
      wr(8'h88, 3);
      check("override set", 8'h8a, status_byte);
      check("override out", 8'h01, {7'h00, override_active});
      nonrec_active = 1'b1;
      see_ev("nonrec event");
      settle();
      check("kept running", 8'h01, {7'h00, outputs_on});
      wr(8'h08, 1);
      check("shut down", 8'h00, {7'h00, outputs_on});
      nonrec_active = 1'b0;
      settle();
      check("recovered", 8'h01, {7'h00, outputs_on});
   endtask
   // manager-set flags cleared by their faults
   task automatic t_flags();
      wr(8'h68, 1);
      check("flags set", 8'h6a, status_byte);
      overtemp_fault = 1'b1;
      see_ev("overtemp event");
      check("overtemp clear", 8'h4a, status_byte);
      fault_event = 1'b1;
      see_ev("fault event");
      check("fault clear", 8'h0a, status_byte);
   endtask
   // frame to another address is refused and ignored
   task automatic t_addr();
      u_ssc_mgr.xfer(SSC_LINK_ADDR ^ 7'h01, {SSC_CMD_STATUS, 8'h10, 8'h9b}, 0);
      settle();
      check("foreign nacks", 8'h04, 8'(u_ssc_mgr.nacks));
      check("foreign ignored", 8'h0a, status_byte);
   endtask
   // record of the negative auxiliary rail, signed constants
   task automatic t_sdr();
      logic [7:0] exp[$] = {SSC_CMD_SDR, 8'h0d, 8'hec, 8'ha6, 8'h02, 8'hfd, 8'h02};
      real y;
      exp.push_back(SSC_FILL_BYTE);
      u_ssc_mgr.xfer(SSC_LINK_ADDR, {SSC_CMD_SDR, 8'h05}, 8);
      foreach (exp[i]) check("record byte", exp[i], u_ssc_mgr.rx_q[i]);
      y = u_ssc_mgr.to_eng(150, $signed(u_ssc_mgr.rx_q[2]), $signed(u_ssc_mgr.rx_q[3]),
                           $signed(u_ssc_mgr.rx_q[4]), $signed(u_ssc_mgr.rx_q[5]));
      check("eng value", 8'h01, {7'h00, y == -12.0});
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge clk_sys);
      bad_count++;
      give_verdict();
   end
   // main sequence
   initial begin
      resetn = 1'b0;
      pin_turn_on_n = 1'b0;
      pin_suppress_n = 1'b1;
      fault_event = 1'b0;
      overtemp_fault = 1'b0;
      nonrec_active = 1'b0;
      do_reset();
      t_pins();
      t_soft();
      t_override();
      t_flags();
      t_addr();
      do_reset();
      t_pins();
      t_sdr();
      give_verdict();
   end
endmodule
